// File: energy_meter_pkg.sv
// Package of command codes, fixed values, field positions and timing counts for the energy meter.
package energy_meter_pkg;
    localparam logic [7:0]  CMD_PAGE      = 8'h00;
    localparam logic [7:0]  CMD_RESTORE   = 8'h16;
    localparam logic [7:0]  CMD_CAP       = 8'h19;
    localparam logic [7:0]  CMD_REV       = 8'h98;
    localparam logic [7:0]  CMD_ID        = 8'hE7;
    localparam logic [7:0]  CMD_LOT       = 8'hC2;
    localparam logic [7:0]  CMD_INFO      = 8'hB6;
    localparam logic [7:0]  CMD_TOOL_A    = 8'hB0;
    localparam logic [7:0]  CMD_TOOL_P    = 8'hB1;
    localparam logic [7:0]  CMD_OEM       = 8'hB2;
    localparam logic [7:0]  CMD_SCR_P     = 8'hB3;
    localparam logic [7:0]  CMD_SCR_G     = 8'hB4;
    localparam logic [7:0]  CMD_RSV_NVM   = 8'hB5;
    localparam logic [7:0]  CMD_RSV_VOL   = 8'hBC;
    localparam logic [7:0]  CMD_ENERGY    = 8'h30;
    localparam logic [7:0]  CMD_RANGE     = 8'h31;
    localparam logic [7:0]  CMD_CAL_GAIN  = 8'h32;
    localparam logic [7:0]  CMD_TEMPCO    = 8'h33;
    localparam logic [7:0]  CMD_PEC_CFG   = 8'h34;
    localparam logic [7:0]  CMD_PIN       = 8'h35;
    localparam logic [7:0]  CMD_IIN       = 8'h36;
    localparam logic [7:0]  CMD_VIN       = 8'h37;

    localparam int          CAP_PEC_BIT   = 7;
    localparam int          CAP_SCL_LSB   = 5;
    localparam int          CAP_ALERT_BIT = 4;
    localparam logic [1:0]  CAP_SCL_400K  = 2'h1;
    localparam logic [7:0]  CAP_VALUE     = {1'b1, CAP_SCL_400K, 1'b1, 4'h0};
    localparam logic [7:0]  REV_VALUE     = 8'h11;
    // Identity code value is arbitrary.
    localparam logic [15:0] ID_VALUE      = 16'h5A3C;
    localparam int          INFO_ECC_BIT  = 5;
    localparam logic [15:0] SCRATCH_RESET = 16'h0000;
    localparam int          NUM_PAGES     = 4;

    localparam logic [1:0]  RANGE_HIGH    = 2'h0;
    localparam logic [1:0]  RANGE_MED     = 2'h1;
    localparam logic [1:0]  RANGE_LOW     = 2'h2;
    localparam logic [23:0] FS_HIGH_UV    = 24'd100000;
    localparam logic [23:0] FS_MED_UV     = 24'd50000;
    localparam logic [23:0] FS_LOW_UV     = 24'd20000;

    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          MS_PERIOD_PS  = 1000000000;
    localparam int          MS_CYCLES     = MS_PERIOD_PS / CLK_PERIOD_PS;
    localparam int          PPM_DIV       = 1000000;
    localparam int          MW_DIV        = 1000;
    localparam int          UJ_PER_MJ     = 1000;
    localparam logic [4:0]  DIV_STEPS     = 5'd24;
endpackage

// File: input_energy_meter.sv
// Input current, power and energy meter with identification and scratchpad command registers.
`timescale 1ns/1ps
module input_energy_meter
    import energy_meter_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES
) (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               link_clk,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_write,
    input  wire logic [7:0]         cmd_code,
    input  wire logic [15:0]        cmd_wdata,
    output logic                    cmd_ready,
    output logic                    rsp_valid,
    output logic                    rsp_err,
    output logic [95:0]             rsp_data,
    input  wire logic               sample_valid,
    input  wire logic [15:0]        input_voltage_sense,
    input  wire logic signed [23:0] input_current_sense,
    input  wire logic signed [7:0]  temp_delta,
    input  wire logic               ecc_clean,
    input  wire logic               nvm_bulk_read_done,
    input  wire logic [31:0]        factory_lot,
    output logic [1:0]              range_sel,
    output logic                    pec_required,
    output logic                    nvm_wr_valid,
    output logic [7:0]              nvm_wr_code,
    output logic [1:0]              nvm_wr_page,
    output logic [15:0]             nvm_wr_data
);
    typedef enum logic [1:0] {S_IDLE, S_DIV, S_POWER} meas_state_t;

    // Link domain: reset synchroniser, command holding and the request/acknowledge toggles.
    logic        lrst_meta_q, lrst_q;
    logic        busy_q, req_tgl_q;
    logic        lwr_q;
    logic [7:0]  lcode_q;
    logic [15:0] lwdata_q;
    logic        ack_s1_q, ack_s2_q, ack_s3_q;
    logic        ack_tgl_q;
    logic [95:0] rsp_word_q;
    logic        rsp_err_q;

    always_ff @(posedge link_clk) begin
        lrst_meta_q <= ~resetn;
        lrst_q      <= lrst_meta_q;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            {ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            busy_q    <= 1'b0;
            req_tgl_q <= 1'b0;
            lwr_q     <= 1'b0;
            lcode_q   <= 8'h00;
            lwdata_q  <= 16'h0000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            rsp_data  <= 96'h0;
        end else begin
            rsp_valid <= 1'b0;
            if (!busy_q && cmd_valid && cmd_ready) begin
                busy_q    <= 1'b1;
                cmd_ready <= 1'b0;
                req_tgl_q <= ~req_tgl_q;
                lwr_q     <= cmd_write;
                lcode_q   <= cmd_code;
                lwdata_q  <= cmd_wdata;
            end else if (busy_q && (ack_s2_q != ack_s3_q)) begin
                busy_q    <= 1'b0;
                cmd_ready <= 1'b1;
                rsp_valid <= 1'b1;
                rsp_err   <= rsp_err_q;
                rsp_data  <= rsp_word_q;
            end else if (!busy_q) begin
                cmd_ready <= 1'b1;
            end
        end
    end

    // Core domain: request synchroniser; the held command words are stable while a request is open.
    logic req_s1_q, req_s2_q, req_s3_q;
    logic serve;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    assign serve = req_s2_q != req_s3_q;

    // Register state.
    logic [1:0]  page_q;
    logic [15:0] tool_a_q, oem_q, scr_g_q;
    logic [15:0] tool_p_q [NUM_PAGES];
    logic [15:0] scr_p_q  [NUM_PAGES];
    logic [15:0] rsv_nvm_q [NUM_PAGES];
    logic [15:0] rsv_vol_q [NUM_PAGES];
    logic [15:0] gain_q, tempco_q;
    logic [31:0] lot_q;
    logic        info_ecc_q, boot_q;
    logic [47:0] energy_q, time_q;
    logic signed [31:0] power_q;
    logic signed [24:0] current_q;
    logic [15:0] vin_q;

    logic        wr_req, nvm_code;
    logic [95:0] rd_word;
    logic        rd_err;

    assign wr_req   = serve && lwr_q;
    assign nvm_code = (lcode_q >= CMD_TOOL_A) && (lcode_q <= CMD_RSV_NVM);

    always_comb begin
        rd_word = 96'h0;
        rd_err  = 1'b0;
        unique case (lcode_q)
            CMD_PAGE:     rd_word[1:0]  = page_q;
            CMD_CAP:      rd_word[7:0]  = CAP_VALUE;
            CMD_REV:      rd_word[7:0]  = REV_VALUE;
            CMD_ID:       rd_word[15:0] = ID_VALUE;
            CMD_LOT:      rd_word[7:0]  = lot_q[page_q*8 +: 8];
            CMD_INFO:     rd_word[INFO_ECC_BIT] = info_ecc_q;
            CMD_TOOL_A:   rd_word[15:0] = tool_a_q;
            CMD_TOOL_P:   rd_word[15:0] = tool_p_q[page_q];
            CMD_OEM:      rd_word[15:0] = oem_q;
            CMD_SCR_P:    rd_word[15:0] = scr_p_q[page_q];
            CMD_SCR_G:    rd_word[15:0] = scr_g_q;
            CMD_RSV_NVM:  rd_word[15:0] = rsv_nvm_q[page_q];
            CMD_RSV_VOL:  rd_word[15:0] = rsv_vol_q[page_q];
            CMD_ENERGY:   rd_word       = {time_q, energy_q};
            CMD_RANGE:    rd_word[1:0]  = range_sel;
            CMD_CAL_GAIN: rd_word[15:0] = gain_q;
            CMD_TEMPCO:   rd_word[15:0] = tempco_q;
            CMD_PEC_CFG:  rd_word[0]    = pec_required;
            CMD_PIN:      rd_word[31:0] = power_q;
            CMD_IIN:      rd_word[24:0] = current_q;
            CMD_VIN:      rd_word[15:0] = vin_q;
            CMD_RESTORE:  rd_word       = 96'h0;
            default:      rd_err        = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rsp_word_q <= 96'h0;
            rsp_err_q  <= 1'b0;
            ack_tgl_q  <= 1'b0;
        end else if (serve) begin
            rsp_word_q <= lwr_q ? 96'h0 : rd_word;
            rsp_err_q  <= rd_err;
            ack_tgl_q  <= ~ack_tgl_q;
        end
    end

    // Writes to the read-only words fall through without effect.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            page_q       <= 2'h0;
            tool_a_q     <= 16'h0000;
            oem_q        <= 16'h0000;
            scr_g_q      <= SCRATCH_RESET;
            gain_q       <= 16'h0001;
            tempco_q     <= 16'h0000;
            range_sel    <= RANGE_HIGH;
            pec_required <= 1'b0;
            for (int i = 0; i < NUM_PAGES; i++) begin
                tool_p_q[i]  <= 16'h0000;
                scr_p_q[i]   <= SCRATCH_RESET;
                rsv_nvm_q[i] <= 16'h0000;
                rsv_vol_q[i] <= 16'h0000;
            end
        end else if (wr_req) begin
            unique case (lcode_q)
                CMD_PAGE:     page_q              <= lwdata_q[1:0];
                CMD_TOOL_A:   tool_a_q            <= lwdata_q;
                CMD_TOOL_P:   tool_p_q[page_q]    <= lwdata_q;
                CMD_OEM:      oem_q               <= lwdata_q;
                CMD_SCR_P:    scr_p_q[page_q]     <= lwdata_q;
                CMD_SCR_G:    scr_g_q             <= lwdata_q;
                CMD_RSV_NVM:  rsv_nvm_q[page_q]   <= lwdata_q;
                CMD_RSV_VOL:  rsv_vol_q[page_q]   <= lwdata_q;
                CMD_CAL_GAIN: gain_q              <= lwdata_q;
                CMD_TEMPCO:   tempco_q            <= lwdata_q;
                CMD_PEC_CFG:  pec_required        <= lwdata_q[0];
                CMD_RANGE: begin
                    if (lwdata_q[1:0] != 2'h3) begin
                        range_sel <= lwdata_q[1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Only the nonvolatile words are passed to the NVM writer.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            nvm_wr_valid <= 1'b0;
            nvm_wr_code  <= 8'h00;
            nvm_wr_page  <= 2'h0;
            nvm_wr_data  <= 16'h0000;
        end else begin
            nvm_wr_valid <= wr_req && nvm_code;
            if (wr_req && nvm_code) begin
                nvm_wr_code <= lcode_q;
                nvm_wr_page <= page_q;
                nvm_wr_data <= lwdata_q;
            end
        end
    end

    // ECC status and lot codes are caught just after reset release and on each refresh event.
    logic info_load;
    assign info_load = boot_q || nvm_bulk_read_done || (wr_req && (lcode_q == CMD_RESTORE));

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            boot_q     <= 1'b1;
            info_ecc_q <= 1'b0;
            lot_q      <= 32'h0;
        end else begin
            boot_q <= 1'b0;
            if (info_load) begin
                info_ecc_q <= ecc_clean;
                lot_q      <= factory_lot;
            end
        end
    end

    // Measurement: range clamp, drift-corrected resistance, serial divide, then power.
    meas_state_t        state_q;
    logic [23:0]        fs_uv, mag_uv, quo_q;
    logic [17:0]        rem_q, div_q, shifted;
    logic [4:0]         step_q;
    logic               neg_q;
    logic signed [47:0] drift;
    logic signed [47:0] r_eff;
    logic signed [41:0] pw_full;

    always_comb begin
        unique case (range_sel)
            RANGE_MED: fs_uv = FS_MED_UV;
            RANGE_LOW: fs_uv = FS_LOW_UV;
            default:   fs_uv = FS_HIGH_UV;
        endcase
        mag_uv = input_current_sense[23] ? 24'(-input_current_sense) : 24'(input_current_sense);
        if (mag_uv > fs_uv) begin
            mag_uv = fs_uv;
        end
        drift = ($signed({32'h0, gain_q}) * $signed({32'h0, tempco_q}) * temp_delta)
                / PPM_DIV;
        r_eff = $signed({32'h0, gain_q}) + drift;
        if (r_eff < 48'sd1) begin
            r_eff = 48'sd1;
        end else if (r_eff > 48'sd262143) begin
            r_eff = 48'sd262143;
        end
        shifted = {rem_q[16:0], quo_q[23]};
        pw_full = $signed({26'h0, vin_q}) * current_q;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q   <= S_IDLE;
            quo_q     <= 24'h0;
            rem_q     <= 18'h0;
            div_q     <= 18'h1;
            step_q    <= 5'h0;
            neg_q     <= 1'b0;
            vin_q     <= 16'h0000;
            current_q <= 25'sh0;
            power_q   <= 32'sh0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (sample_valid) begin
                        quo_q   <= mag_uv;
                        rem_q   <= 18'h0;
                        div_q   <= r_eff[17:0];
                        neg_q   <= input_current_sense[23];
                        vin_q   <= input_voltage_sense;
                        step_q  <= 5'h0;
                        state_q <= S_DIV;
                    end
                end
                S_DIV: begin
                    // Microvolts over milliohms gives milliamps.
                    if (shifted >= div_q) begin
                        rem_q <= shifted - div_q;
                        quo_q <= {quo_q[22:0], 1'b1};
                    end else begin
                        rem_q <= shifted;
                        quo_q <= {quo_q[22:0], 1'b0};
                    end
                    step_q <= step_q + 5'h1;
                    if (step_q == DIV_STEPS - 5'h1) begin
                        state_q <= S_POWER;
                    end
                end
                S_POWER: begin
                    current_q <= neg_q ? -$signed({1'b0, quo_q}) : $signed({1'b0, quo_q});
                    state_q   <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
            power_q <= 32'(pw_full / MW_DIV);
        end
    end

    // Millisecond time base shared by the elapsed time and the energy integration.
    logic [17:0]        ms_cnt_q;
    logic               tick_q;
    logic signed [31:0] resid_q;
    logic signed [32:0] sum_uj;
    logic signed [32:0] delta_mj;
    logic signed [49:0] energy_next;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ms_cnt_q <= 18'h0;
            tick_q   <= 1'b0;
        end else begin
            tick_q <= ms_cnt_q == 18'(MS_COUNT - 1);
            ms_cnt_q <= (ms_cnt_q == 18'(MS_COUNT - 1)) ? 18'h0 : ms_cnt_q + 18'h1;
        end
    end

    always_comb begin
        sum_uj      = 33'(resid_q) + 33'(power_q);
        delta_mj    = sum_uj / UJ_PER_MJ;
        energy_next = $signed({2'b00, energy_q}) + 50'(delta_mj);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            time_q   <= 48'h0;
            energy_q <= 48'h0;
            resid_q  <= 32'sh0;
        end else if (tick_q) begin
            time_q <= time_q + 48'h1;
            if (energy_next < 50'sd0) begin
                energy_q <= 48'h0;
                resid_q  <= 32'sh0;
            end else begin
                energy_q <= energy_next[47:0];
                resid_q  <= 32'(sum_uj - delta_mj * UJ_PER_MJ);
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_read_of(logic [7:0] c);
        serve && !lwr_q && (lcode_q == c);
    endsequence

    a_cap_pec: assert property (s_read_of(CMD_CAP) |=> rsp_word_q[CAP_PEC_BIT])
        else $error("capability pec bit not one");
    a_cap_speed: assert property (s_read_of(CMD_CAP) |=> rsp_word_q[6:5] == 2'b01)
        else $error("capability speed code wrong");
    a_cap_alert: assert property (s_read_of(CMD_CAP) |=> rsp_word_q[4:0] == 5'h10)
        else $error("capability alert or reserved bits wrong");
    a_rev_value: assert property (s_read_of(CMD_REV) |=> rsp_word_q == 96'h11)
        else $error("revision value wrong");
    a_id_fixed: assert property (s_read_of(CMD_ID) |=> rsp_word_q[15:0] == ID_VALUE)
        else $error("identity changed");
    a_info_refresh: assert property (nvm_bulk_read_done |=> info_ecc_q == $past(ecc_clean))
        else $error("info not refreshed");
    a_info_bits: assert property (s_read_of(CMD_INFO) |=> rsp_word_q[15:0] == {10'h0,
        $past(info_ecc_q), 5'h0})
        else $error("info word layout wrong");
    a_scratch_keep: assert property (serve && lwr_q && lcode_q == CMD_CAP
        |=> $stable(scr_g_q) && $stable(page_q))
        else $error("read-only write changed state");
    a_time_step: assert property (tick_q |=> time_q == $past(time_q) + 48'h1)
        else $error("time did not advance");
    a_energy_floor: assert property (tick_q && energy_next < 50'sd0 |=> energy_q == 48'h0)
        else $error("energy underflow");
    a_power_sign: assert property (state_q == S_POWER && neg_q && quo_q != 24'h0
        ##1 vin_q != 16'h0000 |=> power_q <= 32'sh0)
        else $error("reverse power not negative");
    a_div_length: assert property (sample_valid && state_q == S_IDLE
        |=> state_q == S_DIV ##24 state_q == S_POWER)
        else $error("divide length wrong");
endmodule

// File: input_energy_meter_tb.sv
// Self-checking testbench for the input energy meter and its command registers.
`timescale 1ns/1ps
module input_energy_meter_tb;
    import energy_meter_pkg::*;
    logic               core_clk = 1'b0;
    logic               link_clk = 1'b0;
    logic               resetn = 1'b0;
    logic               cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_err;
    logic [7:0]         cmd_code;
    logic [15:0]        cmd_wdata, nvm_wr_data;
    logic [95:0]        rsp_data, rd, e1;
    logic               sample_valid = 1'b0;
    logic [15:0]        input_voltage_sense = 16'h0000;
    logic signed [23:0] input_current_sense = 24'h000000;
    logic signed [7:0]  temp_delta = 8'h64;
    logic               ecc_clean = 1'b1;
    logic               nvm_bulk_read_done = 1'b0;
    logic [31:0]        factory_lot = 32'h44332211;
    logic [1:0]         range_sel, nvm_wr_page;
    logic               pec_required, nvm_wr_valid, er;
    logic [7:0]         nvm_wr_code;
    int                 fails = 0;
    int                 checks = 0;
    int                 nvm_writes = 0;
    int                 n0;

    always #2 core_clk = ~core_clk;
    initial begin
        #3;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge core_clk) if (nvm_wr_valid === 1'b1) nvm_writes++;

    input_energy_meter #(.MS_COUNT(50)) dut (
        .core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_data(rsp_data), .sample_valid(sample_valid),
        .input_voltage_sense(input_voltage_sense), .input_current_sense(input_current_sense),
        .temp_delta(temp_delta), .ecc_clean(ecc_clean), .nvm_bulk_read_done(nvm_bulk_read_done),
        .factory_lot(factory_lot), .range_sel(range_sel), .pec_required(pec_required),
        .nvm_wr_valid(nvm_wr_valid), .nvm_wr_code(nvm_wr_code), .nvm_wr_page(nvm_wr_page),
        .nvm_wr_data(nvm_wr_data));
    link_host host (
        .link_clk(link_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                       input int gap = 0);
        logic hung;
        host.xfer(wr, code, wd, gap, rd, er, hung);
        check(96'(hung), 96'h0);
    endtask

    task automatic sample(input logic [15:0] mv, input logic signed [23:0] uv);
        @(negedge core_clk);
        input_voltage_sense = mv;
        input_current_sense = uv;
        sample_valid = 1'b1;
        @(negedge core_clk);
        sample_valid = 1'b0;
        repeat (30) @(negedge core_clk);
    endtask

    task automatic conclude();
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_ident();
        logic [7:0]  codes [3] = '{CMD_CAP, CMD_REV, CMD_ID};
        logic [15:0] exps [3] = '{16'h00B0, 16'h0011, ID_VALUE};
        check(96'(pec_required), 96'h0);
        for (int i = 0; i < 3; i++) begin
            cmd(1'b0, codes[i], 16'h0000);
            check(rd, 96'(exps[i]));
            cmd(1'b1, codes[i], 16'hFFFF, i);
            cmd(1'b0, codes[i], 16'h0000);
            check(rd, 96'(exps[i]));
        end
        cmd(1'b1, CMD_PEC_CFG, 16'h0001);
        cmd(1'b0, CMD_CAP, 16'h0000);
        check({rd[7:0], 7'h00, pec_required}, 16'hB001);
        cmd(1'b0, 8'hFF, 16'h0000);
        check(96'(er), 96'h1);
    endtask

    task automatic t_scratch();
        n0 = nvm_writes;
        for (int p = 0; p < 4; p++) begin
            cmd(1'b1, CMD_PAGE, 16'(p));
            cmd(1'b0, CMD_SCR_P, 16'h0000);
            check(rd, 96'h0);
            cmd(1'b1, CMD_PAGE, 16'(p));
            cmd(1'b1, CMD_SCR_P, 16'hA500 | 16'(p));
        end
        check({nvm_wr_code, 6'h00, nvm_wr_page, nvm_wr_data}, 32'hB303A503);
        cmd(1'b1, CMD_RSV_VOL, 16'h5555);
        cmd(1'b1, CMD_SCR_G, 16'h1234);
        check(96'(nvm_writes - n0), 96'h5);
        for (int p = 0; p < 4; p++) begin
            cmd(1'b1, CMD_PAGE, 16'(p), 2);
            cmd(1'b0, CMD_SCR_P, 16'h0000);
            check(rd, 96'(16'hA500 | 16'(p)));
            cmd(1'b0, CMD_SCR_G, 16'h0000);
            check(rd, 96'h1234);
        end
        cmd(1'b1, CMD_PAGE, 16'h0002);
        cmd(1'b0, CMD_LOT, 16'h0000);
        check(rd, 96'h33);
    endtask

    task automatic t_info();
        @(negedge core_clk);
        ecc_clean = 1'b0;
        nvm_bulk_read_done = 1'b1;
        @(negedge core_clk);
        nvm_bulk_read_done = 1'b0;
        ecc_clean = 1'b1;
        cmd(1'b0, CMD_INFO, 16'h0000);
        check(rd, 96'h0);
        cmd(1'b1, CMD_RESTORE, 16'h0000);
        cmd(1'b0, CMD_INFO, 16'h0000);
        check(rd, 96'h20);
    endtask

    task automatic t_power();
        cmd(1'b1, CMD_CAL_GAIN, 16'h0002);
        sample(16'd12000, -24'sd10000);
        cmd(1'b0, CMD_IIN, 16'h0000);
        check(rd[24:0], 25'h1FFEC78);
        cmd(1'b0, CMD_PIN, 16'h0000);
        check(rd[31:0], 32'hFFFF15A0);
        cmd(1'b0, CMD_ENERGY, 16'h0000);
        check(rd[47:0], 48'h0);
        cmd(1'b1, CMD_RANGE, 16'(RANGE_LOW));
        cmd(1'b1, CMD_RANGE, 16'h0003);
        check(96'(range_sel), 96'h2);
        sample(16'd12000, 24'sd50000);
        cmd(1'b0, CMD_IIN, 16'h0000);
        check(rd[24:0], 25'h0002710);
        cmd(1'b1, CMD_CAL_GAIN, 16'd20);
        cmd(1'b1, CMD_TEMPCO, 16'd1000);
        sample(16'd12000, 24'sd50000);
        cmd(1'b0, CMD_IIN, 16'h0000);
        check(rd[24:0], 25'h000038D);
    endtask

    task automatic t_energy();
        cmd(1'b1, CMD_TEMPCO, 16'h0000);
        cmd(1'b1, CMD_CAL_GAIN, 16'h0001);
        cmd(1'b1, CMD_RANGE, 16'(RANGE_HIGH));
        sample(16'd1000, 24'sd2000);
        repeat (200) @(negedge core_clk);
        cmd(1'b0, CMD_ENERGY, 16'h0000);
        e1 = rd;
        cmd(1'b0, CMD_ENERGY, 16'h0000, 3);
        check(96'(rd[95:48] != e1[95:48]), 96'h1);
        check(rd[47:0] - e1[47:0], 2 * (rd[95:48] - e1[95:48]));
    endtask

    initial begin
        repeat (12) @(negedge link_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        t_ident();
        t_scratch();
        t_info();
        t_power();
        t_energy();
        conclude();
    end

    initial begin
        #200us;
        fails++;
        conclude();
    end
endmodule

// File: link_host.sv
// Command-link host model that issues one read or write at a time.
`timescale 1ns/1ps
module link_host (
    input  wire logic        link_clk,
    input  wire logic        cmd_ready,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_err,
    input  wire logic [95:0] rsp_data,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Idle code and data lines show the inverse of the last request so stale values are never read.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                        input int gap, output logic [95:0] data, output logic err,
                        output logic hung);
        int n;
        hung = 1'b0;
        n = 0;
        repeat (gap) @(posedge link_clk);
        #1;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_wdata = wd;
        @(posedge link_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code  = ~code;
        cmd_wdata = ~wd;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        hung = (n >= 20);
        data = rsp_data;
        err  = rsp_err;
    endtask
endmodule
